// ---- verilog/wiper_tap_code_encoder.sv ----
// Registered encoder from tap position to hundred-tap wiper data byte
`timescale 1ns/100ps
`default_nettype none
module wiper_tap_code_encoder (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // Position request
   input wire logic signed [wiper_tap_pkg::POS_W-1:0] TAP_POS,
   input wire logic TAP_VALID,
   // Encoded byte
   output logic [wiper_tap_pkg::CODE_W-1:0] WIPER_CODE,
   output logic [wiper_tap_pkg::SEG_W-1:0] SEGMENT,
   output logic CODE_VALID,
   // Range flags
   output logic RANGE_LOW,
   output logic RANGE_HIGH
);

   tap_code_if link ();

   logic [wiper_tap_pkg::CODE_W-1:0] code_d;
   logic [wiper_tap_pkg::CODE_W-1:0] code_q;
   logic [wiper_tap_pkg::SEG_W-1:0] seg_d;
   logic [wiper_tap_pkg::SEG_W-1:0] seg_q;
   logic valid_d;
   logic valid_q;
   logic low_d;
   logic low_q;
   logic high_d;
   logic high_q;

   assign link.tap_pos = TAP_POS;

   tap_code_core core (
      .link(link.encoder)
   );

   always_comb begin
      code_d = code_q;
      seg_d = seg_q;
      low_d = low_q;
      high_d = high_q;
      valid_d = TAP_VALID;
      if (TAP_VALID) begin
         code_d = link.code;
         seg_d = link.segment;
         low_d = link.below;
         high_d = link.above;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         code_q <= wiper_tap_pkg::CODE_RESET;
         seg_q <= wiper_tap_pkg::SEG_ASC_LOW;
         valid_q <= 1'b0;
         low_q <= 1'b0;
         high_q <= 1'b0;
      end else begin
         code_q <= code_d;
         seg_q <= seg_d;
         valid_q <= valid_d;
         low_q <= low_d;
         high_q <= high_d;
      end
   end

   assign WIPER_CODE = code_q;
   assign SEGMENT = seg_q;
   assign CODE_VALID = valid_q;
   assign RANGE_LOW = low_q;
   assign RANGE_HIGH = high_q;

   // Request classes for checks
   logic req_seg0;
   logic req_seg1;
   logic req_seg2;
   logic req_seg3;
   logic req_neg;
   logic req_big;

   // Signed window test shared by the four quarter request classes
   function automatic logic in_window(
      input logic signed [wiper_tap_pkg::POS_W-1:0] p,
      input logic signed [wiper_tap_pkg::POS_W-1:0] lo,
      input logic signed [wiper_tap_pkg::POS_W-1:0] hi
   );
      return (p >= lo) && (p <= hi);
   endfunction

   assign req_seg0 = TAP_VALID && in_window(TAP_POS, 8'sh00, 8'sh18);
   assign req_seg1 = TAP_VALID && in_window(TAP_POS, 8'sh19, 8'sh31);
   assign req_seg2 = TAP_VALID && in_window(TAP_POS, 8'sh32, 8'sh4A);
   assign req_seg3 = TAP_VALID && in_window(TAP_POS, 8'sh4B, 8'sh63);
   assign req_neg = TAP_VALID && (TAP_POS < 0);
   assign req_big = TAP_VALID && (TAP_POS > 8'sh63);

   code_valid_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      TAP_VALID |=> CODE_VALID
   ) else $error("code valid did not follow request");

   code_hold_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      (!TAP_VALID ##1 !TAP_VALID) |=> ($stable(WIPER_CODE) && !CODE_VALID)
   ) else $error("code changed without request");

   ident_map_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      req_seg0 |=> (WIPER_CODE == $past(TAP_POS)) && (SEGMENT == 2'h0)
   ) else $error("first quarter code wrong");

   desc_low_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      req_seg1 |=> (WIPER_CODE == 8'(8'h51 - $past(TAP_POS)))
         && (WIPER_CODE <= 8'h38) && (WIPER_CODE >= 8'h20)
   ) else $error("second quarter code wrong");

   asc_high_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      req_seg2 |=> (WIPER_CODE == 8'(8'h0E + $past(TAP_POS)))
         && (WIPER_CODE >= 8'h40) && (WIPER_CODE <= 8'h58)
   ) else $error("third quarter code wrong");

   desc_high_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      req_seg3 |=> (WIPER_CODE == 8'(8'hC3 - $past(TAP_POS)))
         && (WIPER_CODE <= 8'h78) && (WIPER_CODE >= 8'h60)
   ) else $error("fourth quarter code wrong");

   below_zero_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      req_neg |=> (WIPER_CODE == 8'h00) && RANGE_LOW && !RANGE_HIGH
   ) else $error("negative position not zeroed");

   above_top_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      req_big |=> (WIPER_CODE == 8'h60) && RANGE_HIGH && !RANGE_LOW
   ) else $error("large position not saturated");

   legal_flags_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      (req_seg0 || req_seg1 || req_seg2 || req_seg3) |=> (!RANGE_LOW && !RANGE_HIGH)
   ) else $error("range flag on legal position");

   valid_pulse_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      !TAP_VALID |=> !CODE_VALID
   ) else $error("code valid without request");

   flags_hold_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      !TAP_VALID |=> $stable(SEGMENT) && $stable(RANGE_LOW) && $stable(RANGE_HIGH)
   ) else $error("quarter or flags changed without request");

   quarter_seg_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      (req_seg1 |=> (SEGMENT == wiper_tap_pkg::SEG_DESC_LOW))
         and (req_seg2 |=> (SEGMENT == wiper_tap_pkg::SEG_ASC_HIGH))
         and (req_seg3 |=> (SEGMENT == wiper_tap_pkg::SEG_DESC_HIGH))
   ) else $error("quarter number wrong");

   clamp_seg_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      (req_neg |=> (SEGMENT == wiper_tap_pkg::SEG_ASC_LOW))
         and (req_big |=> (SEGMENT == wiper_tap_pkg::SEG_DESC_HIGH))
   ) else $error("clamped quarter number wrong");

   reset_clear_a: assert property (
      @(posedge CLK_SYS)
      !RST_N |=> (WIPER_CODE == wiper_tap_pkg::CODE_RESET) && !CODE_VALID
         && !RANGE_LOW && !RANGE_HIGH && (SEGMENT == wiper_tap_pkg::SEG_ASC_LOW)
   ) else $error("outputs not cleared by reset");

   // Scenario coverage
   seam_low_c: cover property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      (TAP_VALID && TAP_POS == 8'sh18) ##1 (TAP_VALID && TAP_POS == 8'sh19)
   );

   seam_mid_c: cover property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      (TAP_VALID && TAP_POS == 8'sh31) ##1 (TAP_VALID && TAP_POS == 8'sh32)
   );

   seam_high_c: cover property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      (TAP_VALID && TAP_POS == 8'sh4A) ##1 (TAP_VALID && TAP_POS == 8'sh4B)
   );

   clamp_both_c: cover property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      req_neg ##1 req_big
   );

   hold_after_c: cover property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      req_big ##1 !TAP_VALID ##1 !TAP_VALID
   );

endmodule
`default_nettype wire

// ---- verilog/wiper_tap_pkg.sv ----
// Constants and decode helpers for the hundred-tap wiper code encoder
`default_nettype none
package wiper_tap_pkg;

   // Widths
   localparam int POS_W = 8;
   localparam int CODE_W = 8;
   localparam int TAP_W = 7;
   localparam int SEG_W = 2;

   // Tap range of the hundred_tap_potentiometer
   localparam logic [TAP_W-1:0] TAP_COUNT = 7'h64;
   localparam logic [TAP_W-1:0] MAX_TAP = 7'h63;
   localparam logic signed [POS_W-1:0] MAX_POS_S = 8'sh63;

   // Segment starts, 25 positions each
   localparam logic [TAP_W-1:0] SEG1_START = 7'h19;
   localparam logic [TAP_W-1:0] SEG2_START = 7'h32;
   localparam logic [TAP_W-1:0] SEG3_START = 7'h4B;

   // Segment numbers
   localparam logic [SEG_W-1:0] SEG_ASC_LOW = 2'h0;
   localparam logic [SEG_W-1:0] SEG_DESC_LOW = 2'h1;
   localparam logic [SEG_W-1:0] SEG_ASC_HIGH = 2'h2;
   localparam logic [SEG_W-1:0] SEG_DESC_HIGH = 2'h3;

   // Segment formula constants
   localparam logic [CODE_W-1:0] SEG1_BASE = 8'h51;
   localparam logic [CODE_W-1:0] SEG2_BASE = 8'h0E;
   localparam logic [CODE_W-1:0] SEG3_BASE = 8'hC3;

   // Reset and out-of-range values
   localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
   localparam logic [CODE_W-1:0] CODE_BELOW = 8'h00;
   localparam logic [CODE_W-1:0] CODE_TOP = 8'h60;

   // Quarter in which a legal tap position falls
   function automatic logic [SEG_W-1:0] segment_of(input logic [TAP_W-1:0] p);
      logic [SEG_W-1:0] s;
      s = SEG_ASC_LOW;
      if (p >= SEG3_START) begin
         s = SEG_DESC_HIGH;
      end else if (p >= SEG2_START) begin
         s = SEG_ASC_HIGH;
      end else if (p >= SEG1_START) begin
         s = SEG_DESC_LOW;
      end
      return s;
   endfunction

endpackage
`default_nettype wire

// ---- verilog/tap_code_if.sv ----
// Carrier between the encoder core and its registered wrapper
`timescale 1ns/100ps
`default_nettype none
interface tap_code_if;
   logic signed [wiper_tap_pkg::POS_W-1:0] tap_pos;
   logic [wiper_tap_pkg::CODE_W-1:0] code;
   logic [wiper_tap_pkg::SEG_W-1:0] segment;
   logic below;
   logic above;

   modport encoder (
      input tap_pos,
      output code,
      output segment,
      output below,
      output above
   );

   modport user (
      output tap_pos,
      input code,
      input segment,
      input below,
      input above
   );
endinterface
`default_nettype wire

// ---- verilog/tap_code_core.sv ----
// Combinational tap position to wiper data byte translation
`timescale 1ns/100ps
`default_nettype none
module tap_code_core (
   // Position in, code out
   tap_code_if.encoder link
);

   logic [wiper_tap_pkg::TAP_W-1:0] clamp;
   logic [wiper_tap_pkg::SEG_W-1:0] seg;

   always_comb begin
      clamp = {wiper_tap_pkg::TAP_W{1'b0}};
      link.below = 1'b0;
      link.above = 1'b0;
      if (link.tap_pos < 0) begin
         link.below = 1'b1;
      end else if (link.tap_pos > wiper_tap_pkg::MAX_POS_S) begin
         link.above = 1'b1;
         clamp = wiper_tap_pkg::MAX_TAP;
      end else begin
         clamp = link.tap_pos[wiper_tap_pkg::TAP_W-1:0];
      end
   end

   always_comb begin
      seg = wiper_tap_pkg::segment_of(clamp);
      link.segment = seg;
      case (seg)
         wiper_tap_pkg::SEG_ASC_LOW: begin
            link.code = {1'b0, clamp};
         end
         wiper_tap_pkg::SEG_DESC_LOW: begin
            link.code = wiper_tap_pkg::SEG1_BASE - {1'b0, clamp};
         end
         wiper_tap_pkg::SEG_ASC_HIGH: begin
            link.code = wiper_tap_pkg::SEG2_BASE + {1'b0, clamp};
         end
         wiper_tap_pkg::SEG_DESC_HIGH: begin
            link.code = wiper_tap_pkg::SEG3_BASE - {1'b0, clamp};
         end
         default: begin
            link.code = wiper_tap_pkg::CODE_RESET;
         end
      endcase
   end

endmodule
`default_nettype wire

// ---- test/tap_host_model.sv ----
// Host model issuing tap position requests
`timescale 1ns/100ps
`default_nettype none
module tap_host_model (
   // Clock
   input wire logic CLK_SYS,
   // Request
   output logic signed [wiper_tap_pkg::POS_W-1:0] TAP_POS,
   output logic TAP_VALID
);
   initial begin
      TAP_POS = 8'sh00;
      TAP_VALID = 1'b0;
   end
   // One cycle of request or idle, set at the falling edge
   task automatic put(input logic signed [wiper_tap_pkg::POS_W-1:0] p, input logic v);
      @(negedge CLK_SYS);
      TAP_POS <= p;
      TAP_VALID <= v;
   endtask
endmodule
`default_nettype wire

// ---- test/tb_wiper_tap_code_encoder.sv ----
// Self-checking bench for the wiper tap code encoder
`timescale 1ns/100ps
`default_nettype none
module tb_wiper_tap_code_encoder;
   logic clk_sys;
   logic rst_n;
   logic signed [7:0] tap_pos;
   logic tap_valid;
   logic [7:0] wiper_code;
   logic [1:0] segment;
   logic code_valid;
   logic range_low;
   logic range_high;
   logic [12:0] resp;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;

   assign resp = {code_valid, range_low, range_high, segment, wiper_code};

   tap_host_model host (.CLK_SYS(clk_sys), .TAP_POS(tap_pos), .TAP_VALID(tap_valid));

   wiper_tap_code_encoder uut (
      .CLK_SYS(clk_sys), .RST_N(rst_n), .TAP_POS(tap_pos), .TAP_VALID(tap_valid),
      .WIPER_CODE(wiper_code), .SEGMENT(segment), .CODE_VALID(code_valid),
      .RANGE_LOW(range_low), .RANGE_HIGH(range_high)
   );

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         conclude();
      end
   end

   task automatic cmp_resp(input logic [12:0] got, input logic [12:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Valid, low, high, segment, code for one taken position
   function automatic logic [12:0] exp_resp(input int p);
      logic [1:0] s;
      logic [7:0] c;
      if (p < 0) return 13'h1800;
      if (p > 99) return 13'h1760;
      s = 2'(p / 25);
      c = (s == 2'h0) ? 8'(p) : (s == 2'h1) ? 8'(81 - p) : (s == 2'h2) ? 8'(14 + p) : 8'(195 - p);
      return {3'h4, s, c};
   endfunction

   task automatic t_reset(input int n);
      host.put(8'sh00, 1'b0);
      rst_n <= 1'b0;
      repeat (n) @(negedge clk_sys);
      cmp_resp(resp, 13'h0000);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      cmp_resp(resp, 13'h0000);
      $display("Reset test done");
   endtask

   // Negative then too large, back to back
   task automatic t_flip();
      host.put(8'shFE, 1'b1);
      host.put(8'sh70, 1'b1);
      cmp_resp(resp, exp_resp(-2));
      host.put(8'sh05, 1'b0);
      cmp_resp(resp, exp_resp(112));
      $display("Flip test done");
   endtask

   // Back to back positions a..b, then idle cycles with a changing position
   task automatic t_span(input int a, input int b);
      for (int i = a; i <= b; i++) begin
         host.put(8'(i), 1'b1);
         if (i > a) cmp_resp(resp, exp_resp(i - 1));
      end
      host.put(~8'(b), 1'b0);
      cmp_resp(resp, exp_resp(b));
      host.put(8'(b) ^ 8'h55, 1'b0);
      cmp_resp(resp, exp_resp(b) & 13'h0FFF);
      $display("Span test %0d to %0d done", a, b);
   endtask

   initial begin
      rst_n = 1'b0;
      t_reset(20);
      t_span(0, 99);
      t_span(23, 26);
      t_span(25, 49);
      t_span(48, 51);
      t_span(50, 74);
      t_span(73, 76);
      t_span(75, 99);
      t_span(-3, 2);
      t_span(-128, -126);
      t_span(97, 102);
      t_span(125, 127);
      t_flip();
      host.put(8'sh32, 1'b1);
      t_reset(2);
      t_span(49, 50);
      conclude();
   end
endmodule
`default_nettype wire
